//--- design/rtf_top.sv
// Relay timer functions: retentive on-delay, wiping relay, edge wiping relay,
// pulse generator and random generator, with APB registers.
// Assumes control inputs come from logic on core_clk; pwr_up marks return of supply.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "rtf_defs.svh"
module rtf_top #(
	parameter int TW = 16,
	parameter int unsigned TICK_CYCLES = `RTF_TICK_CYCLES
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// APB slave.
	input wire rtf_pkg::rtf_apb_req_t apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Program logic.
	input wire rtf_pkg::rtf_ctl_t ctl,
	input wire logic pwr_up,
	output rtf_pkg::rtf_out_t q
);
	import rtf_pkg::*;

	localparam logic [TW-1:0] ONE = TW'(1);
	localparam logic [TW-1:0] RST_VAL [0:`RTF_NUM_RW-1] = '{
		TW'(`RTF_RST_CTRL), TW'(`RTF_RST_PERIOD), TW'(`RTF_RST_PERIOD),
		TW'(`RTF_RST_PERIOD), TW'(`RTF_RST_PERIOD), TW'(`RTF_RST_COUNT),
		TW'(`RTF_RST_PERIOD), TW'(`RTF_RST_PERIOD), TW'(`RTF_RST_PERIOD),
		TW'(`RTF_RST_PERIOD)};

	logic tick;
	logic [TW-1:0] rnd_val;

	// Shared timebase for every block.
	rtf_tick_gen #(.CYC(TICK_CYCLES)) u_tick (
		.core_clk(core_clk),
		.rst(rst),
		.tick(tick)
	);

	// Free-running random source.
	rtf_lfsr #(.W(TW)) u_lfsr (
		.core_clk(core_clk),
		.rst(rst),
		.value(rnd_val)
	);

	logic [TW-1:0] regs_ff [0:`RTF_NUM_RW-1];
	logic [TW-1:0] nxt_regs [0:`RTF_NUM_RW-1];
	logic [31:0] prdata_ff, nxt_prdata;
	logic pready_ff, nxt_pready;
	logic pslverr_ff, nxt_pslverr;
	logic [3:0] idx;
	logic addr_ok;
	logic [31:0] rd_mux;

	rtf_ctl_t prev_ff;
	rtf_out_t q_ff, nxt_q;
	logic ond_run_ff, nxt_ond_run;
	logic [TW-1:0] ond_ta_ff, nxt_ond_ta;
	logic [TW-1:0] wip_ta_ff, nxt_wip_ta;
	rtf_etr_st_t etr_st_ff, nxt_etr_st;
	logic [TW-1:0] etr_ta_ff, nxt_etr_ta;
	logic [3:0] etr_n_ff, nxt_etr_n;
	logic apg_hi_ff, nxt_apg_hi;
	logic [TW-1:0] apg_ta_ff, nxt_apg_ta;
	rtf_rnd_st_t rnd_st_ff, nxt_rnd_st;
	logic [TW-1:0] rnd_ta_ff, nxt_rnd_ta;
	logic [TW-1:0] rnd_tgt_ff, nxt_rnd_tgt;

	// Address decode: the low bits of the byte address pick the word.
	assign idx = apb_req.paddr[5:2];
	assign addr_ok = (apb_req.paddr[1:0] == 2'h0) && (apb_req.paddr[7:6] == 2'h0)
		&& (idx <= `RTF_IDX_OND_TA);

	// Read mux; status and elapsed time are live views of block state.
	always_comb begin
		rd_mux = 32'h0;
		if (idx == `RTF_IDX_STATUS) begin
			rd_mux = {27'h0, q_ff};
		end else if (idx == `RTF_IDX_OND_TA) begin
			rd_mux = 32'(ond_ta_ff);
		end else if (idx < 4'(`RTF_NUM_RW)) begin
			rd_mux = 32'(regs_ff[idx]);
		end
	end

	// Answer in the access phase; reads are sampled in the setup cycle.
	always_comb begin
		nxt_pready = apb_req.psel & ~apb_req.penable;
		nxt_prdata = 32'h0;
		nxt_pslverr = 1'b0;
		for (int i = 0; i < `RTF_NUM_RW; i++) begin
			nxt_regs[i] = regs_ff[i];
		end
		if (apb_req.psel && !apb_req.penable) begin
			nxt_pslverr = ~addr_ok;
			if (!apb_req.pwrite && addr_ok) begin
				nxt_prdata = rd_mux;
			end
		end
		// Status words are read-only; writes there are dropped without error.
		if (apb_req.psel && apb_req.penable && pready_ff && apb_req.pwrite && addr_ok
			&& idx < 4'(`RTF_NUM_RW)) begin
			nxt_regs[idx] = apb_req.pwdata[TW-1:0];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `RTF_NUM_RW; i++) begin
				regs_ff[i] <= RST_VAL[i];
			end
			prdata_ff <= 32'h0;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			regs_ff <= nxt_regs;
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	// Configured durations and options.
	logic [4:0] ret;
	logic [TW-1:0] ond_t, wip_t, etr_lo, etr_hi, apg_hi, apg_lo, rnd_hi, rnd_lo;
	logic [3:0] etr_n;
	assign ret = regs_ff[`RTF_IDX_CTRL][4:0];
	assign ond_t = regs_ff[`RTF_IDX_OND_T];
	assign wip_t = regs_ff[`RTF_IDX_WIP_T];
	assign etr_lo = regs_ff[`RTF_IDX_ETR_LOW];
	assign etr_hi = regs_ff[`RTF_IDX_ETR_HIGH];
	assign etr_n = regs_ff[`RTF_IDX_ETR_N][3:0];
	assign apg_hi = regs_ff[`RTF_IDX_APG_HIGH];
	assign apg_lo = regs_ff[`RTF_IDX_APG_LOW];
	assign rnd_hi = regs_ff[`RTF_IDX_RND_HIGH];
	assign rnd_lo = regs_ff[`RTF_IDX_RND_LOW];

	// Edges of the program inputs, all on core_clk so no synchroniser is needed.
	logic ond_rise, wip_rise, wip_fall, etr_rise, apg_rise, rnd_rise, rnd_fall;
	assign ond_rise = ctl.ond_trg & ~prev_ff.ond_trg;
	assign wip_rise = ctl.wip_trg & ~prev_ff.wip_trg;
	assign wip_fall = ~ctl.wip_trg & prev_ff.wip_trg;
	assign etr_rise = ctl.etr_trg & ~prev_ff.etr_trg;
	assign apg_rise = ctl.apg_en & ~prev_ff.apg_en;
	assign rnd_rise = ctl.rnd_en & ~prev_ff.rnd_en;
	assign rnd_fall = ~ctl.rnd_en & prev_ff.rnd_en;

	// Random delays scaled by multiply-and-shift, so the draw never exceeds the limit.
	logic [2*TW:0] prod_on, prod_off;
	assign prod_on = {{(TW+1){1'b0}}, rnd_val} * {{TW{1'b0}}, ({1'b0, rnd_hi} + {{TW{1'b0}}, 1'b1})};
	assign prod_off = {{(TW+1){1'b0}}, rnd_val} * {{TW{1'b0}}, ({1'b0, rnd_lo} + {{TW{1'b0}}, 1'b1})};

	// Next state of all five timing blocks.
	always_comb begin
		nxt_q = q_ff;
		nxt_ond_run = ond_run_ff;
		nxt_ond_ta = ond_ta_ff;
		nxt_wip_ta = wip_ta_ff;
		nxt_etr_st = etr_st_ff;
		nxt_etr_ta = etr_ta_ff;
		nxt_etr_n = etr_n_ff;
		nxt_apg_hi = apg_hi_ff;
		nxt_apg_ta = apg_ta_ff;
		nxt_rnd_st = rnd_st_ff;
		nxt_rnd_ta = rnd_ta_ff;
		nxt_rnd_tgt = rnd_tgt_ff;
		// Retentive on-delay; once running or set, new edges are ignored.
		if (ond_rise && !ond_run_ff && !q_ff.ond) begin
			nxt_ond_run = 1'b1;
			nxt_ond_ta = '0;
		end else if (ond_run_ff && tick) begin
			nxt_ond_ta = ond_ta_ff + ONE;
			if (ond_ta_ff + ONE >= ond_t) begin
				nxt_q.ond = 1'b1;
				nxt_ond_run = 1'b0;
			end
		end
		if (ctl.ond_clr) begin
			nxt_q.ond = 1'b0;
			nxt_ond_ta = '0;
			nxt_ond_run = 1'b0;
		end
		// Wiping relay with pulse output.
		if (wip_rise) begin
			nxt_q.wip = 1'b1;
			nxt_wip_ta = '0;
		end else if (wip_fall) begin
			nxt_q.wip = 1'b0;
		end else if (q_ff.wip && tick) begin
			nxt_wip_ta = wip_ta_ff + ONE;
			if (wip_ta_ff + ONE >= wip_t) begin
				nxt_q.wip = 1'b0;
			end
		end
		// Edge triggered wiping relay; a zero count behaves as one cycle.
		if (ctl.etr_clr) begin
			nxt_etr_st = ETR_IDLE;
			nxt_etr_ta = '0;
			nxt_etr_n = 4'h0;
			nxt_q.etr = 1'b0;
		end else if (etr_rise) begin
			nxt_etr_st = ETR_LOW;
			nxt_etr_ta = '0;
			nxt_etr_n = 4'h0;
			nxt_q.etr = 1'b0;
		end else if (tick) begin
			unique case (etr_st_ff)
				ETR_LOW: begin
					nxt_etr_ta = etr_ta_ff + ONE;
					if (etr_ta_ff + ONE >= etr_lo) begin
						nxt_etr_st = ETR_HIGH;
						nxt_etr_ta = '0;
						nxt_q.etr = 1'b1;
					end
				end
				ETR_HIGH: begin
					nxt_etr_ta = etr_ta_ff + ONE;
					if (etr_ta_ff + ONE >= etr_hi) begin
						nxt_q.etr = 1'b0;
						nxt_etr_ta = '0;
						nxt_etr_n = etr_n_ff + 4'h1;
						nxt_etr_st = (etr_n_ff + 4'h1 >= etr_n) ? ETR_IDLE : ETR_LOW;
					end
				end
				ETR_IDLE: begin
					nxt_etr_ta = etr_ta_ff;
				end
				default: begin
					nxt_etr_st = ETR_IDLE;
				end
			endcase
		end
		// Asynchronous pulse generator; each enable starts with the high phase.
		if (apg_rise) begin
			nxt_apg_hi = 1'b1;
			nxt_apg_ta = '0;
		end else if (ctl.apg_en && tick) begin
			nxt_apg_ta = apg_ta_ff + ONE;
			if (apg_ta_ff + ONE >= (apg_hi_ff ? apg_hi : apg_lo)) begin
				nxt_apg_hi = ~apg_hi_ff;
				nxt_apg_ta = '0;
			end
		end
		nxt_q.apg = ctl.apg_en & (nxt_apg_hi ^ ctl.apg_inv);
		// Random generator; an opposite edge cancels and restarts the other delay.
		if (rnd_rise) begin
			nxt_rnd_st = RND_ON_DLY;
			nxt_rnd_ta = '0;
			nxt_rnd_tgt = prod_on[2*TW-1:TW];
		end else if (rnd_fall) begin
			nxt_rnd_st = RND_OFF_DLY;
			nxt_rnd_ta = '0;
			nxt_rnd_tgt = prod_off[2*TW-1:TW];
		end else if (rnd_st_ff != RND_IDLE) begin
			if (rnd_ta_ff >= rnd_tgt_ff) begin
				nxt_q.rnd = (rnd_st_ff == RND_ON_DLY) && ctl.rnd_en;
				nxt_rnd_st = RND_IDLE;
				nxt_rnd_ta = '0;
			end else if (tick) begin
				nxt_rnd_ta = rnd_ta_ff + ONE;
			end
		end
		// Return of supply: blocks without the retain option start afresh.
		if (pwr_up) begin
			if (!ret[0]) begin
				nxt_q.ond = 1'b0;
				nxt_ond_ta = '0;
				nxt_ond_run = 1'b0;
			end
			if (!ret[1]) begin
				nxt_q.wip = 1'b0;
				nxt_wip_ta = '0;
			end
			if (!ret[2]) begin
				nxt_q.etr = 1'b0;
				nxt_etr_ta = '0;
				nxt_etr_st = ETR_IDLE;
			end
			// The output drops for this cycle and then restarts in the high phase.
			if (!ret[3]) begin
				nxt_apg_ta = '0;
				nxt_apg_hi = 1'b1;
				nxt_q.apg = 1'b0;
			end
			nxt_rnd_st = RND_IDLE;
			nxt_rnd_ta = '0;
			nxt_q.rnd = 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prev_ff <= '0;
			q_ff <= '0;
			ond_run_ff <= 1'b0;
			ond_ta_ff <= '0;
			wip_ta_ff <= '0;
			etr_st_ff <= ETR_IDLE;
			etr_ta_ff <= '0;
			etr_n_ff <= 4'h0;
			apg_hi_ff <= 1'b1;
			apg_ta_ff <= '0;
			rnd_st_ff <= RND_IDLE;
			rnd_ta_ff <= '0;
			rnd_tgt_ff <= '0;
		end else begin
			prev_ff <= ctl;
			q_ff <= nxt_q;
			ond_run_ff <= nxt_ond_run;
			ond_ta_ff <= nxt_ond_ta;
			wip_ta_ff <= nxt_wip_ta;
			etr_st_ff <= nxt_etr_st;
			etr_ta_ff <= nxt_etr_ta;
			etr_n_ff <= nxt_etr_n;
			apg_hi_ff <= nxt_apg_hi;
			apg_ta_ff <= nxt_apg_ta;
			rnd_st_ff <= nxt_rnd_st;
			rnd_ta_ff <= nxt_rnd_ta;
			rnd_tgt_ff <= nxt_rnd_tgt;
		end
	end

	// Every output comes straight from a flip-flop.
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign q = q_ff;

	// Checks on the block behaviour.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_ond_set;
		ond_run_ff && tick && (ond_ta_ff + ONE >= ond_t) && !ctl.ond_clr && !pwr_up |=> q.ond;
	endproperty
	a_ond_set: assert property (p_ond_set) else $error("on-delay missed expiry");

	property p_ond_hold;
		ond_run_ff && ond_rise && !tick && !ctl.ond_clr && !pwr_up |=> $stable(ond_ta_ff);
	endproperty
	a_ond_hold: assert property (p_ond_hold) else $error("on-delay count disturbed");

	property p_ond_clr;
		ctl.ond_clr |=> !q.ond && ond_ta_ff == '0 && !ond_run_ff;
	endproperty
	a_ond_clr: assert property (p_ond_clr) else $error("on-delay clear failed");

	property p_wip_rise;
		wip_rise && !pwr_up |=> q.wip && wip_ta_ff == '0;
	endproperty
	a_wip_rise: assert property (p_wip_rise) else $error("wiping relay did not set");

	property p_wip_fall;
		wip_fall |=> !q.wip;
	endproperty
	a_wip_fall: assert property (p_wip_fall) else $error("wiping relay did not end");

	property p_etr_clr;
		ctl.etr_clr |=> !q.etr && etr_ta_ff == '0 && etr_st_ff == ETR_IDLE;
	endproperty
	a_etr_clr: assert property (p_etr_clr) else $error("edge relay clear failed");

	property p_etr_restart;
		etr_rise && !ctl.etr_clr && !pwr_up |=> etr_st_ff == ETR_LOW && !q.etr && etr_n_ff == 4'h0;
	endproperty
	a_etr_restart: assert property (p_etr_restart) else $error("edge relay no restart");

	property p_apg_off;
		!ctl.apg_en |=> !q.apg;
	endproperty
	a_apg_off: assert property (p_apg_off) else $error("pulse generator active while off");

	property p_rnd_rise;
		rnd_rise && !pwr_up |=> rnd_st_ff == RND_ON_DLY && rnd_ta_ff == '0 && rnd_tgt_ff <= rnd_hi;
	endproperty
	a_rnd_rise: assert property (p_rnd_rise) else $error("random on-delay bad start");

	property p_rnd_set;
		$rose(q.rnd) |-> $past(ctl.rnd_en) && $past(rnd_st_ff) == RND_ON_DLY;
	endproperty
	a_rnd_set: assert property (p_rnd_set) else $error("random output set unenabled");

	property p_rnd_fall;
		rnd_fall && !pwr_up |=> rnd_st_ff == RND_OFF_DLY && rnd_ta_ff == '0 && rnd_tgt_ff <= rnd_lo;
	endproperty
	a_rnd_fall: assert property (p_rnd_fall) else $error("random off-delay bad start");

	property p_rnd_clr;
		$fell(q.rnd) |-> $past(pwr_up)
			|| ($past(rnd_st_ff) == RND_OFF_DLY && !$past(ctl.rnd_en));
	endproperty
	a_rnd_clr: assert property (p_rnd_clr) else $error("random output cleared early");

	property p_rnd_pwr;
		pwr_up |=> rnd_st_ff == RND_IDLE && rnd_ta_ff == '0 && !q.rnd;
	endproperty
	a_rnd_pwr: assert property (p_rnd_pwr) else $error("random state kept at power-up");

	c_ond_done: cover property ($rose(q.ond));
	c_etr_pulse: cover property (etr_st_ff == ETR_HIGH ##1 etr_st_ff == ETR_LOW);
	c_rnd_on: cover property ($rose(q.rnd));
	c_apg_inv: cover property (ctl.apg_en && ctl.apg_inv && q.apg);
endmodule : rtf_top
`default_nettype wire

//--- design/rtf_defs.svh
// Constants for the relay timer function blocks: clocking, register map and resets.
// Assumes a 100 MHz core clock and an APB register bus with 32-bit data.
`ifndef RTF_DEFS_SVH
`define RTF_DEFS_SVH

`define RTF_CLK_PERIOD_NS 10
`define RTF_TICK_NS 10000000
`define RTF_TICK_CYCLES (`RTF_TICK_NS / `RTF_CLK_PERIOD_NS)

`define RTF_IDX_CTRL 4'h0
`define RTF_IDX_OND_T 4'h1
`define RTF_IDX_WIP_T 4'h2
`define RTF_IDX_ETR_LOW 4'h3
`define RTF_IDX_ETR_HIGH 4'h4
`define RTF_IDX_ETR_N 4'h5
`define RTF_IDX_APG_HIGH 4'h6
`define RTF_IDX_APG_LOW 4'h7
`define RTF_IDX_RND_HIGH 4'h8
`define RTF_IDX_RND_LOW 4'h9
`define RTF_IDX_STATUS 4'ha
`define RTF_IDX_OND_TA 4'hb
`define RTF_NUM_RW 10

`define RTF_RST_PERIOD 16'h000a
`define RTF_RST_COUNT 16'h0001
`define RTF_RST_CTRL 16'h0000
`define RTF_LFSR_SEED 16'hace1
`define RTF_LFSR_TAPS 16'hb400

`endif

//--- design/rtf_pkg.sv
// Types shared by the relay timer function blocks.
// Assumes nothing of its surroundings.
package rtf_pkg;

	// Requests arriving from the APB master.
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} rtf_apb_req_t;

	// Inputs driven by the surrounding program logic.
	typedef struct packed {
		logic ond_trg;
		logic ond_clr;
		logic wip_trg;
		logic etr_trg;
		logic etr_clr;
		logic apg_en;
		logic apg_inv;
		logic rnd_en;
	} rtf_ctl_t;

	// Switched outputs of the five blocks.
	typedef struct packed {
		logic rnd;
		logic apg;
		logic etr;
		logic wip;
		logic ond;
	} rtf_out_t;

	typedef enum logic [1:0] {ETR_IDLE, ETR_LOW, ETR_HIGH} rtf_etr_st_t;
	typedef enum logic [1:0] {RND_IDLE, RND_ON_DLY, RND_OFF_DLY} rtf_rnd_st_t;

endpackage : rtf_pkg

//--- design/rtf_tick_gen.sv
// Timebase divider giving a one-cycle tick every CYC core clocks.
// Assumes a single clock domain.
`timescale 1ns/10ps
`default_nettype none
module rtf_tick_gen #(
	parameter int unsigned CYC = 1000000
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Timebase.
	output logic tick
);
	logic [31:0] cnt_ff;
	logic [31:0] nxt_cnt;
	logic tick_ff;
	logic nxt_tick;

	// Count down and fire when the count wraps.
	always_comb begin
		nxt_tick = (cnt_ff == 32'h0);
		nxt_cnt = nxt_tick ? 32'(CYC - 1) : cnt_ff - 32'h1;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= 32'h0;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	assign tick = tick_ff;
endmodule : rtf_tick_gen
`default_nettype wire

//--- design/rtf_lfsr.sv
// Free-running Galois LFSR used as the random source.
// Assumes a single clock domain; never reaches the all-zero state.
`timescale 1ns/10ps
`default_nettype none
`include "rtf_defs.svh"
module rtf_lfsr #(
	parameter int W = 16,
	parameter logic [W-1:0] TAPS = `RTF_LFSR_TAPS,
	parameter logic [W-1:0] SEED = `RTF_LFSR_SEED
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Random value.
	output logic [W-1:0] value
);
	logic [W-1:0] sr_ff;
	logic [W-1:0] nxt_sr;

	// Shift every clock so the draw depends on when the edge arrives.
	always_comb begin
		nxt_sr = {1'b0, sr_ff[W-1:1]} ^ (sr_ff[0] ? TAPS : {W{1'b0}});
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sr_ff <= SEED;
		end else begin
			sr_ff <= nxt_sr;
		end
	end

	assign value = sr_ff;
endmodule : rtf_lfsr
`default_nettype wire

//--- verif/rtf_prog_model.sv
// Model of the control program that feeds the timer blocks with levels.
// Assumes core_clk and rst of the block; the bench sets the wanted levels.
`timescale 1ns/10ps
`default_nettype none
module rtf_prog_model (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Levels wanted by the bench.
	input wire rtf_pkg::rtf_ctl_t want_ctl,
	input wire logic want_pwr,
	// Levels seen by the block.
	output rtf_pkg::rtf_ctl_t ctl,
	output logic pwr_up
);
	import rtf_pkg::*;

	rtf_ctl_t ctl_ff;
	rtf_ctl_t nxt_ctl;
	logic pwr_ff;
	logic nxt_pwr;

	// A program scan updates its outputs once per clock, so every level is registered.
	always_comb begin
		nxt_ctl = want_ctl;
		nxt_pwr = want_pwr;
	end

	// Cold reset leaves all program outputs low.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctl_ff <= '0;
			pwr_ff <= 1'b0;
		end else begin
			ctl_ff <= nxt_ctl;
			pwr_ff <= nxt_pwr;
		end
	end

	assign ctl = ctl_ff;
	assign pwr_up = pwr_ff;
endmodule : rtf_prog_model
`default_nettype wire

//--- verif/relay_timer_functions_tb_top.sv
// Self-checking bench for the relay timer blocks and their APB registers.
// Assumes the block is built with a 4-cycle timebase to keep the run short.
`timescale 1ns/10ps
`default_nettype none
module relay_timer_functions_tb_top;
	import rtf_pkg::*;

	localparam int Q_OND = 0;
	localparam int Q_WIP = 1;
	localparam int Q_ETR = 2;
	localparam int Q_APG = 3;
	localparam int Q_RND = 4;
	localparam int C_OND_TRG = 7;
	localparam int C_ETR_TRG = 4;
	localparam int C_ETR_CLR = 3;
	// On-delay 4, wiping 3, edge low 2 high 2 count 2, pulse 3/2, random 0/0 ticks.
	localparam logic [31:0] CFG [9] = '{32'h4, 32'h3, 32'h2, 32'h2, 32'h2, 32'h3, 32'h2, 32'h0, 32'h0};

	logic core_clk = 1'b0;
	logic rst;
	rtf_apb_req_t apb_req;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	rtf_ctl_t want_ctl;
	rtf_ctl_t ctl;
	logic want_pwr;
	logic pwr_up;
	rtf_out_t q;
	int failures = 0;
	int samples_checked = 0;

	rtf_top #(.TICK_CYCLES(4)) rtf_top_i (.core_clk(core_clk), .rst(rst), .apb_req(apb_req),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ctl(ctl), .pwr_up(pwr_up), .q(q));
	rtf_prog_model rtf_prog_model_i (.core_clk(core_clk), .rst(rst), .want_ctl(want_ctl),
		.want_pwr(want_pwr), .ctl(ctl), .pwr_up(pwr_up));

	// Free-running 100 MHz clock.
	always #5 core_clk = ~core_clk;

	task automatic end_sim();
		if (failures == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_sim

	task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk_word

	task automatic chk_bit(input string name, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %b seen %b", name, exp, got);
		end
	endtask : chk_bit

	// Counts and cycle spans are checked against a window, since tick phase is free.
	task automatic chk_win(input string name, input int n, input int lo, input int hi);
		samples_checked++;
		if (n < lo || n > hi) begin
			failures++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi, n);
		end
	endtask : chk_win

	// One APB transfer; the request is held until pready is sampled high at an edge.
	task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge core_clk);
		apb_req.psel <= 1'b1;
		apb_req.penable <= 1'b0;
		apb_req.pwrite <= wr;
		apb_req.paddr <= addr;
		apb_req.pwdata <= wd;
		@(posedge core_clk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			failures++;
			$display("[FAIL] apb_pready expected 1 seen %b", pready);
		end
		rd = prdata;
		err = pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask : apb_xfer

	task automatic wr_reg(input logic [7:0] addr, input logic [31:0] wd);
		logic [31:0] rd;
		logic err;
		apb_xfer(1'b1, addr, wd, rd, err);
		chk_bit("write_err", 1'b0, err);
	endtask : wr_reg

	// Returns the number of edges until the output bit shows the wanted level.
	task automatic wait_q(input int idx, input logic val, input int max, output int n);
		n = 0;
		while (q[idx] !== val && n < max) begin
			@(posedge core_clk);
			n++;
		end
	endtask : wait_q

	task automatic count_rises(input int idx, input int cycles, output int k);
		logic prev;
		k = 0;
		prev = q[idx];
		repeat (cycles) begin
			@(posedge core_clk);
			if (prev === 1'b0 && q[idx] === 1'b1) begin
				k++;
			end
			prev = q[idx];
		end
	endtask : count_rises

	task automatic pulse(input int b);
		@(posedge core_clk);
		want_ctl[b] <= 1'b1;
		repeat (2) @(posedge core_clk);
		want_ctl[b] <= 1'b0;
	endtask : pulse

	// A hang anywhere ends the run as a failure.
	initial begin
		repeat (6000) @(posedge core_clk);
		failures++;
		end_sim();
	end

	// Main sequence.
	initial begin
		logic [31:0] rd;
		logic err;
		int n;
		int k;
		apb_req = '0;
		want_ctl = '0;
		want_pwr = 1'b0;
		rst = 1'b1;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		// Register reset values, then an unmapped and a misaligned address.
		for (int a = 0; a < 10; a++) begin
			apb_xfer(1'b0, 8'(a * 4), '0, rd, err);
			chk_word("reg_reset", (a == 0) ? 32'h0 : ((a == 5) ? 32'h1 : 32'ha), rd);
		end
		apb_xfer(1'b0, 8'h30, '0, rd, err);
		chk_bit("unmapped_err", 1'b1, err);
		apb_xfer(1'b1, 8'h02, 32'h7, rd, err);
		chk_bit("misaligned_err", 1'b1, err);
		foreach (CFG[i]) wr_reg(8'(4 + 4 * i), CFG[i]);
		apb_xfer(1'b0, 8'h14, '0, rd, err);
		chk_word("etr_count_reg", 32'h2, rd);
		// On-delay with a second trigger mid-count; a restart would land past the window.
		@(posedge core_clk);
		fork
			begin
				want_ctl.ond_trg <= 1'b1;
				repeat (3) @(posedge core_clk);
				want_ctl.ond_trg <= 1'b0;
				repeat (7) @(posedge core_clk);
				want_ctl.ond_trg <= 1'b1;
			end
			wait_q(Q_OND, 1'b1, 40, n);
		join
		chk_win("ond_delay", n, 12, 21);
		@(posedge core_clk);
		want_ctl.ond_trg <= 1'b0;
		want_ctl.ond_clr <= 1'b1;
		wait_q(Q_OND, 1'b0, 6, n);
		chk_win("ond_clear", n, 1, 5);
		want_ctl.ond_clr <= 1'b0;
		apb_xfer(1'b1, 8'h2c, 32'h5, rd, err);
		apb_xfer(1'b0, 8'h2c, '0, rd, err);
		chk_word("ond_elapsed", 32'h0, rd);
		// Supply return clears the block only when retention is off.
		wr_reg(8'h00, 32'h0);
		pulse(C_OND_TRG);
		wait_q(Q_OND, 1'b1, 40, n);
		want_pwr <= 1'b1;
		@(posedge core_clk);
		want_pwr <= 1'b0;
		wait_q(Q_OND, 1'b0, 6, n);
		chk_win("ond_pwr_clear", n, 1, 5);
		wr_reg(8'h00, 32'h1);
		pulse(C_OND_TRG);
		wait_q(Q_OND, 1'b1, 40, n);
		want_pwr <= 1'b1;
		@(posedge core_clk);
		want_pwr <= 1'b0;
		repeat (6) @(posedge core_clk);
		chk_bit("ond_pwr_keep", 1'b1, q[Q_OND]);
		// Wiping relay: full pulse, then a pulse cut short by the falling trigger.
		want_ctl.wip_trg <= 1'b1;
		wait_q(Q_WIP, 1'b1, 8, n);
		chk_win("wip_set", n, 1, 5);
		wait_q(Q_WIP, 1'b0, 30, n);
		chk_win("wip_end", n, 7, 14);
		want_ctl.wip_trg <= 1'b0;
		repeat (2) @(posedge core_clk);
		want_ctl.wip_trg <= 1'b1;
		wait_q(Q_WIP, 1'b1, 8, n);
		want_ctl.wip_trg <= 1'b0;
		wait_q(Q_WIP, 1'b0, 30, n);
		chk_win("wip_abort", n, 1, 5);
		// Edge relay: low phase first, two pulses, restart and clear.
		pulse(C_ETR_TRG);
		wait_q(Q_ETR, 1'b1, 30, n);
		chk_win("etr_low", n, 3, 12);
		count_rises(Q_ETR, 60, k);
		chk_win("etr_repeat", k, 1, 1);
		pulse(C_ETR_TRG);
		wait_q(Q_ETR, 1'b1, 30, n);
		pulse(C_ETR_TRG);
		count_rises(Q_ETR, 70, k);
		chk_win("etr_restart", k, 2, 2);
		pulse(C_ETR_TRG);
		wait_q(Q_ETR, 1'b1, 30, n);
		pulse(C_ETR_CLR);
		// The clear reaches the output at the edge the pulse returns on; look one later.
		@(posedge core_clk);
		chk_bit("etr_clear", 1'b0, q[Q_ETR]);
		count_rises(Q_ETR, 40, k);
		chk_win("etr_clear_idle", k, 0, 0);
		// Pulse generator: cycling, inversion while enabled, none while disabled.
		want_ctl.apg_en <= 1'b1;
		wait_q(Q_APG, 1'b1, 8, n);
		chk_win("apg_start", n, 1, 5);
		count_rises(Q_APG, 64, k);
		chk_win("apg_cycles", k, 2, 4);
		wait_q(Q_APG, 1'b1, 30, n);
		want_ctl.apg_inv <= 1'b1;
		wait_q(Q_APG, 1'b0, 6, n);
		chk_win("apg_inv", n, 1, 4);
		want_ctl.apg_en <= 1'b0;
		repeat (4) @(posedge core_clk);
		chk_bit("apg_off", 1'b0, q[Q_APG]);
		count_rises(Q_APG, 30, k);
		chk_win("apg_off_idle", k, 0, 0);
		want_ctl.apg_inv <= 1'b0;
		// Random generator with zero maxima: both delays expire at once.
		want_ctl.rnd_en <= 1'b1;
		wait_q(Q_RND, 1'b1, 10, n);
		chk_win("rnd_on", n, 1, 6);
		want_ctl.rnd_en <= 1'b0;
		wait_q(Q_RND, 1'b0, 10, n);
		chk_win("rnd_off", n, 1, 6);
		// A one-cycle enable is cancelled by its own falling edge before it expires.
		want_ctl.rnd_en <= 1'b1;
		@(posedge core_clk);
		want_ctl.rnd_en <= 1'b0;
		count_rises(Q_RND, 12, k);
		chk_win("rnd_cancel", k, 0, 0);
		end_sim();
	end
endmodule : relay_timer_functions_tb_top
`default_nettype wire
